// ===== include/gsh_pkg.sv
// Shared constants and types for the instrument bus status and handshake block.
package gsh_pkg;
  // ==========================================================================
  // Bus line layout. Line levels: 1 = high = unasserted, 0 = low = asserted.
  localparam int CTL_W    = 6;
  localparam int DIO_W    = 8;
  localparam int CTL_DAV  = 0;
  localparam int CTL_NRFD = 1;
  localparam int CTL_NDAC = 2;
  localparam int CTL_EOI  = 3;
  localparam int CTL_SRQ  = 4;
  localparam int CTL_ATN  = 5;
  // ==========================================================================
  // Status byte patterns, bit 0 is the lowest bit of the byte.
  localparam logic [7:0] ST_NORMAL     = 8'h00;
  localparam logic [7:0] ST_COMPLETE   = 8'h02;
  localparam logic [7:0] ST_EXEC_ERR   = 8'h22;
  localparam logic [7:0] ST_CMD_ERR    = 8'h21;
  localparam logic [7:0] ST_POWER_ON   = 8'h41;
  localparam logic [7:0] ST_CHECK_FAIL = 8'h63;
  localparam logic [7:0] ST_REQUEST    = 8'h50;
  localparam logic [7:0] ST_XFER       = 8'h90;
  localparam logic [7:0] BUSY_MASK     = 8'h10;
  localparam logic [7:0] RQS_MASK      = 8'h40;
  localparam logic [3:0] XFER_STORE    = 4'h0;
  localparam logic [3:0] XFER_SEND     = 4'h2;
  localparam logic [3:0] XFER_READ     = 4'h3;
  localparam logic [3:0] XFER_EXT      = 4'h4;
  localparam logic [3:0] XFER_TEXT     = 4'h5;
  // ==========================================================================
  // Request classes, index into the enable vector.
  localparam int CLS_W        = 6;
  localparam int CLS_COMPLETE = 0;
  localparam int CLS_EXEC_ERR = 1;
  localparam int CLS_CMD_ERR  = 2;
  localparam int CLS_REMOTE   = 3;
  localparam int CLS_XFER     = 4;
  localparam int CLS_GLOBAL   = 5;
  localparam logic [CLS_W-1:0] ENA_RESET = 6'h00;
  // ==========================================================================
  // Interface messages seen with attention asserted (low seven bits).
  localparam logic [6:0] MSG_SPE    = 7'h18;
  localparam logic [6:0] MSG_SPD    = 7'h19;
  localparam logic [6:0] MSG_UNL    = 7'h3F;
  localparam logic [6:0] MSG_UNT    = 7'h5F;
  localparam logic [1:0] MSG_LISTEN = 2'h1;
  localparam logic [1:0] MSG_TALK   = 2'h2;
  // ==========================================================================
  // Timing.
  localparam int CLK_NS     = 40;
  localparam int SETTLE_NS  = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================================
  // Controller register map.
  localparam logic [3:0] REG_TX   = 4'h0;
  localparam logic [3:0] REG_CTRL = 4'h4;
  localparam logic [3:0] REG_RX   = 4'h8;
  localparam logic [3:0] REG_STAT = 4'hC;
  // ==========================================================================
  // Handshake state machines.
  typedef enum logic [1:0] {
    SRC_GEN = 2'b00, SRC_DLY = 2'b01, SRC_TRS = 2'b10, SRC_WNS = 2'b11
  } gsh_src_e;
  typedef enum logic [2:0] {
    ACC_IDLE = 3'b000, ACC_NRS = 3'b001, ACC_CRS = 3'b010, ACC_CDS = 3'b011,
    ACC_WNS  = 3'b100
  } gsh_acc_e;
endpackage

// ===== include/gsh_bus_if.sv
// Interface joining the instrument end and the controller end on the bus wires.
`timescale 1ns/1ps
interface gsh_bus_if;
  import gsh_pkg::*;
  logic [DIO_W-1:0] devDioOut;
  logic [DIO_W-1:0] devDioOe;
  logic [CTL_W-1:0] devCtlOut;
  logic [CTL_W-1:0] devCtlOe;
  logic [DIO_W-1:0] ctlrDioOut;
  logic [DIO_W-1:0] ctlrDioOe;
  logic [CTL_W-1:0] ctlrCtlOut;
  logic [CTL_W-1:0] ctlrCtlOe;
  logic [DIO_W-1:0] dioLine;
  logic [CTL_W-1:0] ctlLine;
  // Open-drain wired-or: a line is low when any party drives it low.
  assign dioLine = ~((devDioOe & ~devDioOut) | (ctlrDioOe & ~ctlrDioOut));
  assign ctlLine = ~((devCtlOe & ~devCtlOut) | (ctlrCtlOe & ~ctlrCtlOut));
  modport device (
    output devDioOut, devDioOe, devCtlOut, devCtlOe,
    input  dioLine, ctlLine
  );
  modport controller (
    output ctlrDioOut, ctlrDioOe, ctlrCtlOut, ctlrCtlOe,
    input  dioLine, ctlLine
  );
endinterface

// ===== src/gsh_link_hs.sv
// Source and acceptor three-wire handshake engine with line synchronisers.
`timescale 1ns/1ps
module gsh_link_hs
  import gsh_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYC
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [DIO_W-1:0] dioIn,
  input  wire logic [CTL_W-1:0] ctlIn,
  input  wire logic             txValid,
  input  wire logic [7:0]       txByte,
  input  wire logic             txEoi,
  output logic                  txDone,
  input  wire logic             acceptEn,
  input  wire logic             rxReady,
  output logic [7:0]            rxByte,
  output logic                  rxEoi,
  output logic                  rxAtn,
  output logic                  rxStrobe,
  output logic [CTL_W-1:0]      ctlLevel,
  output logic [DIO_W-1:0]      dioOe,
  output logic [3:0]            hsOe
);
  typedef struct packed {
    logic [13:0] s1;
    logic [13:0] s2;
    gsh_src_e    src;
    gsh_acc_e    acc;
    logic [7:0]  txByte;
    logic        txEoi;
    logic [7:0]  cnt;
    logic        txDone;
    logic [7:0]  rxByte;
    logic        rxEoi;
    logic        rxAtn;
    logic        rxStrobe;
    logic [7:0]  dioOe;
    logic [3:0]  hsOe;
  } gsh_hs_s;

  gsh_hs_s r;
  gsh_hs_s next_r;
  logic    davLow;
  logic    nrfdHigh;
  logic    ndacHigh;

  // ==========================================================================
  // Next state.
  always_comb begin
    next_r = r;
    next_r.s1 = {ctlIn, dioIn};
    next_r.s2 = r.s1;
    next_r.txDone = 1'b0;
    next_r.rxStrobe = 1'b0;
    davLow = ~r.s2[DIO_W+CTL_DAV];
    nrfdHigh = r.s2[DIO_W+CTL_NRFD];
    ndacHigh = r.s2[DIO_W+CTL_NDAC];
    case (r.src)
      SRC_GEN: begin
        // The cycle after a finished byte is skipped so a held request is not sent twice.
        if (txValid && !r.txDone) begin
          next_r.txByte = txByte;
          next_r.txEoi = txEoi;
          next_r.cnt = 8'h00;
          next_r.src = SRC_DLY;
        end
      end
      SRC_DLY: begin
        if (r.cnt != 8'(SETTLE)) begin
          next_r.cnt = r.cnt + 8'h01;
        end else if (nrfdHigh) begin
          next_r.src = SRC_TRS;
        end
      end
      SRC_TRS: begin
        if (ndacHigh) begin
          next_r.src = SRC_WNS;
        end
      end
      default: begin
        next_r.src = SRC_GEN;
        next_r.txDone = 1'b1;
      end
    endcase
    case (r.acc)
      ACC_IDLE: begin
        if (acceptEn) begin
          next_r.acc = ACC_NRS;
        end
      end
      ACC_NRS: begin
        if (!acceptEn) begin
          next_r.acc = ACC_IDLE;
        end else if (rxReady) begin
          next_r.acc = ACC_CRS;
        end
      end
      ACC_CRS: begin
        if (!acceptEn) begin
          next_r.acc = ACC_IDLE;
        end else if (davLow) begin
          next_r.acc = ACC_CDS;
        end
      end
      ACC_CDS: begin
        next_r.rxByte = ~r.s2[7:0];
        next_r.rxEoi = ~r.s2[DIO_W+CTL_EOI];
        next_r.rxAtn = ~r.s2[DIO_W+CTL_ATN];
        next_r.rxStrobe = 1'b1;
        next_r.acc = ACC_WNS;
      end
      ACC_WNS: begin
        if (!davLow) begin
          next_r.acc = ACC_NRS;
        end
      end
      default: next_r.acc = ACC_IDLE;
    endcase
    // Drive enables follow the next state so that they leave flip-flops directly.
    next_r.dioOe = (next_r.src == SRC_DLY || next_r.src == SRC_TRS) ? next_r.txByte : 8'h00;
    next_r.hsOe[CTL_DAV] = (next_r.src == SRC_TRS);
    next_r.hsOe[CTL_EOI] = next_r.txEoi && (next_r.src == SRC_DLY || next_r.src == SRC_TRS);
    next_r.hsOe[CTL_NRFD] = (next_r.acc == ACC_NRS) || (next_r.acc == ACC_CDS) ||
                            (next_r.acc == ACC_WNS);
    next_r.hsOe[CTL_NDAC] = (next_r.acc == ACC_NRS) || (next_r.acc == ACC_CRS) ||
                            (next_r.acc == ACC_CDS);
  end

  // ==========================================================================
  // State register; the line synchroniser idles at the released level.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{s1: 14'h3FFF, s2: 14'h3FFF, src: SRC_GEN, acc: ACC_IDLE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign txDone   = r.txDone;
  assign rxByte   = r.rxByte;
  assign rxEoi    = r.rxEoi;
  assign rxAtn    = r.rxAtn;
  assign rxStrobe = r.rxStrobe;
  assign ctlLevel = r.s2[13:8];
  assign dioOe    = r.dioOe;
  assign hsOe     = r.hsOe;
endmodule // gsh_link_hs

// ===== src/gsh_instrument.sv
// Instrument end: status byte, service request gating, serial poll and handshakes.
// Operation
// - Bit four reports busy; idle byte otherwise zero.
// - Bit six marks an active service request.
// - Completion or end of program reports pattern 2.
// - Execution and command errors report own patterns.
// - Power-on and self-check failure report fixed patterns; the code adds bit four to them while busy.
// - Explicit request command reports fixed byte 80.
// - Transfer start reports prefix plus command nibble.
// - Completion requests suppressible by their disable.
// - Execution error requests suppressible by their disable.
// - Command error requests suppressible by their disable.
// - Explicit request service suppressible by its disable.
// - Transfer initiation requests suppressible by disable.
// - Global disable blocks all but power-on and self-check failure.
// - Controller must enable globally and per class.
// - Poll returns status byte, then releases request.
// - Idle: source silent, acceptors hold both lines.
// - Source puts byte and end flag together.
// - Acceptors release ready line; slowest one governs.
// - Source validates data only after ready seen.
// - Acceptor reasserts not-ready on seeing valid.
// - Acceptor releases not-accepted after taking byte.
// - Valid removed; both sides return to start.
`timescale 1ns/1ps
module gsh_instrument
  import gsh_pkg::*;
#(
  parameter logic [4:0] MY_ADDR = 5'h01,
  parameter int         SETTLE  = SETTLE_CYC
) (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  gsh_bus_if.device                       bus,
  input  wire logic                       busy,
  input  wire logic                       evComplete,
  input  wire logic                       evEndProgram,
  input  wire logic                       evExecError,
  input  wire logic                       evCommandError,
  input  wire logic                       evRequestCommand,
  input  wire logic                       evTransfer,
  input  wire logic [3:0]                 transferCode,
  input  wire logic                       evCheckFail,
  input  wire logic [gsh_pkg::CLS_W-1:0]  enableSet,
  input  wire logic [gsh_pkg::CLS_W-1:0]  enableClear,
  input  wire logic                       txValid,
  input  wire logic [7:0]                 txData,
  input  wire logic                       txEnd,
  output logic                            txDone,
  output logic [7:0]                      rxData,
  output logic                            rxEnd,
  output logic                            rxValid,
  output logic [7:0]                      statusByte,
  output logic                            srqActive,
  output logic [gsh_pkg::CLS_W-1:0]       enables
);
  import gsh_pkg::*;

  typedef struct packed {
    logic [7:0]       base;
    logic             busyType;
    logic             srqType;
    logic             srq;
    logic [CLS_W-1:0] ena;
    logic             spoll;
    logic             talk;
    logic             listen;
    logic             pollSent;
    logic [7:0]       statusByte;
    logic [7:0]       rxData;
    logic             rxEnd;
    logic             rxValid;
  } gsh_inst_s;

  gsh_inst_s        r;
  gsh_inst_s        next_r;
  logic             hsTxValid;
  logic [7:0]       hsTxByte;
  logic             hsTxEoi;
  logic             hsTxDone;
  logic             hsAccept;
  logic [7:0]       hsRxByte;
  logic             hsRxEoi;
  logic             hsRxAtn;
  logic             hsRxStrobe;
  logic [CTL_W-1:0] lvl;
  logic [DIO_W-1:0] hsDioOe;
  logic [3:0]       hsOe;
  logic             atnOn;
  logic             pollTalk;
  logic [6:0]       msg;

  // ==========================================================================
  // Handshake engine.
  gsh_link_hs #(.SETTLE(SETTLE)) u_hs (
    .clk      (clk),
    .rstn     (rstn),
    .dioIn    (bus.dioLine),
    .ctlIn    (bus.ctlLine),
    .txValid  (hsTxValid),
    .txByte   (hsTxByte),
    .txEoi    (hsTxEoi),
    .txDone   (hsTxDone),
    .acceptEn (hsAccept),
    .rxReady  (1'b1),
    .rxByte   (hsRxByte),
    .rxEoi    (hsRxEoi),
    .rxAtn    (hsRxAtn),
    .rxStrobe (hsRxStrobe),
    .ctlLevel (lvl),
    .dioOe    (hsDioOe),
    .hsOe     (hsOe)
  );

  assign atnOn    = ~lvl[CTL_ATN];
  assign pollTalk = r.talk && r.spoll && !atnOn;
  // Every device accepts interface messages while attention is asserted.
  assign hsAccept = atnOn || (r.listen && !r.talk);
  // The poll byte is sent once per addressing; further reads need a new poll.
  assign hsTxValid = pollTalk ? !r.pollSent : (r.talk && !atnOn && txValid);
  assign hsTxByte  = pollTalk ? r.statusByte : txData;
  assign hsTxEoi   = pollTalk ? 1'b0 : txEnd;
  assign msg       = hsRxByte[6:0];

  // ==========================================================================
  // Status, request and addressing state.
  always_comb begin
    next_r = r;
    next_r.rxValid = 1'b0;
    if (atnOn) begin
      next_r.pollSent = 1'b0;
    end
    if (hsRxStrobe && hsRxAtn) begin
      if (msg == MSG_SPE) begin
        next_r.spoll = 1'b1;
      end else if (msg == MSG_SPD) begin
        next_r.spoll = 1'b0;
      end else if (msg == MSG_UNL) begin
        next_r.listen = 1'b0;
      end else if (msg == MSG_UNT) begin
        next_r.talk = 1'b0;
      end else if (msg[6:5] == MSG_LISTEN && msg[4:0] == MY_ADDR) begin
        next_r.listen = 1'b1;
      end else if (msg[6:5] == MSG_TALK) begin
        // Another talker being addressed silences this one.
        next_r.talk = (msg[4:0] == MY_ADDR);
      end
    end
    if (hsRxStrobe && !hsRxAtn && r.listen) begin
      next_r.rxData = hsRxByte;
      next_r.rxEnd = hsRxEoi;
      next_r.rxValid = 1'b1;
    end
    // Enable commands; clear wins when both arrive for one class.
    next_r.ena = (r.ena | enableSet) & ~enableClear;
    if (pollTalk && hsTxDone) begin
      next_r.pollSent = 1'b1;
      if (r.srq) begin
        next_r.srq = 1'b0;
        next_r.base = ST_NORMAL;
        next_r.busyType = 1'b1;
        next_r.srqType = 1'b0;
      end
    end
    // Events are applied after the poll release so a new request is not lost.
    if (evCheckFail) begin
      next_r.base = ST_CHECK_FAIL;
      next_r.busyType = 1'b1;
      next_r.srqType = 1'b0;
      next_r.srq = 1'b1;
    end else if (evCommandError) begin
      next_r.base = ST_CMD_ERR;
      next_r.busyType = 1'b0;
      next_r.srqType = 1'b1;
      next_r.srq = next_r.srq || (r.ena[CLS_GLOBAL] && r.ena[CLS_CMD_ERR]);
    end else if (evExecError) begin
      next_r.base = ST_EXEC_ERR;
      next_r.busyType = 1'b0;
      next_r.srqType = 1'b1;
      next_r.srq = next_r.srq || (r.ena[CLS_GLOBAL] && r.ena[CLS_EXEC_ERR]);
    end else if (evTransfer) begin
      next_r.base = ST_XFER | {4'h0, transferCode};
      next_r.busyType = 1'b0;
      next_r.srqType = 1'b1;
      next_r.srq = next_r.srq || (r.ena[CLS_GLOBAL] && r.ena[CLS_XFER]);
    end else if (evRequestCommand) begin
      next_r.base = ST_REQUEST;
      next_r.busyType = 1'b0;
      next_r.srqType = 1'b0;
      next_r.srq = next_r.srq || (r.ena[CLS_GLOBAL] && r.ena[CLS_REMOTE]);
    end else if (evComplete || evEndProgram) begin
      next_r.base = ST_COMPLETE;
      next_r.busyType = 1'b0;
      next_r.srqType = 1'b1;
      next_r.srq = next_r.srq || (r.ena[CLS_GLOBAL] && r.ena[CLS_COMPLETE]);
    end
    next_r.statusByte = next_r.base |
                        ((next_r.busyType && busy) ? BUSY_MASK : 8'h00) |
                        ((next_r.srqType && next_r.srq) ? RQS_MASK : 8'h00);
  end

  // ==========================================================================
  // The power-on request is pending from reset and cannot be masked.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{base: ST_POWER_ON, busyType: 1'b1, srq: 1'b1, ena: ENA_RESET,
             statusByte: ST_POWER_ON, default: '0};
    end else begin
      r <= next_r;
    end
  end

  assign bus.devDioOut = '0;
  assign bus.devDioOe  = hsDioOe;
  assign bus.devCtlOut = '0;
  assign bus.devCtlOe  = {1'b0, r.srq, hsOe};
  assign txDone        = hsTxDone && !pollTalk;
  assign rxData        = r.rxData;
  assign rxEnd         = r.rxEnd;
  assign rxValid       = r.rxValid;
  assign statusByte    = r.statusByte;
  assign srqActive     = r.srq;
  assign enables       = r.ena;
endmodule // gsh_instrument

// ===== src/gsh_controller.sv
// Controller end: software register port driving the source and acceptor handshakes.
`timescale 1ns/1ps
module gsh_controller
  import gsh_pkg::*;
#(
  parameter int SETTLE = SETTLE_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  gsh_bus_if.controller    bus,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata
);
  import gsh_pkg::*;

  typedef struct packed {
    logic        atn;
    logic        listen;
    logic        txPend;
    logic [7:0]  txByte;
    logic        txEoi;
    logic [7:0]  rxByte;
    logic        rxEoi;
    logic        rxValid;
    logic [15:0] rdata;
  } gsh_ctlr_s;

  gsh_ctlr_s        r;
  gsh_ctlr_s        next_r;
  logic             hsTxDone;
  logic [7:0]       hsRxByte;
  logic             hsRxEoi;
  logic             hsRxStrobe;
  logic [CTL_W-1:0] lvl;
  logic [DIO_W-1:0] hsDioOe;
  logic [3:0]       hsOe;

  gsh_link_hs #(.SETTLE(SETTLE)) u_hs (
    .clk      (clk),
    .rstn     (rstn),
    .dioIn    (bus.dioLine),
    .ctlIn    (bus.ctlLine),
    .txValid  (r.txPend),
    .txByte   (r.txByte),
    .txEoi    (r.txEoi),
    .txDone   (hsTxDone),
    .acceptEn (r.listen && !r.atn),
    .rxReady  (!r.rxValid),
    .rxByte   (hsRxByte),
    .rxEoi    (hsRxEoi),
    .rxAtn    (),
    .rxStrobe (hsRxStrobe),
    .ctlLevel (lvl),
    .dioOe    (hsDioOe),
    .hsOe     (hsOe)
  );

  // ==========================================================================
  // Register port; a byte waits in the acceptor until software reads it.
  always_comb begin
    next_r = r;
    next_r.rdata = 16'h0000;
    if (hsTxDone) begin
      next_r.txPend = 1'b0;
    end
    if (wr && addr == REG_TX && !r.txPend) begin
      next_r.txByte = wdata[7:0];
      next_r.txEoi = wdata[8];
      next_r.txPend = 1'b1;
    end
    if (wr && addr == REG_CTRL) begin
      next_r.atn = wdata[0];
      next_r.listen = wdata[1];
    end
    if (rd) begin
      case (addr)
        REG_RX: begin
          next_r.rdata = {6'h00, r.rxValid, r.rxEoi, r.rxByte};
          next_r.rxValid = 1'b0;
        end
        REG_STAT: next_r.rdata = {13'h0000, r.rxValid, r.txPend, ~lvl[CTL_SRQ]};
        REG_CTRL: next_r.rdata = {14'h0000, r.listen, r.atn};
        default:  next_r.rdata = 16'h0000;
      endcase
    end
    // A byte arriving while the old one is read is kept: set wins.
    if (hsRxStrobe) begin
      next_r.rxByte = hsRxByte;
      next_r.rxEoi = hsRxEoi;
      next_r.rxValid = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign bus.ctlrDioOut = '0;
  assign bus.ctlrDioOe  = hsDioOe;
  assign bus.ctlrCtlOut = '0;
  assign bus.ctlrCtlOe  = {r.atn, 1'b0, hsOe};
  assign rdata          = r.rdata;
endmodule // gsh_controller

// ===== sim/gsh_checker.sv
// Concurrent checks on the handshake wires between the two ends.
`timescale 1ns/1ps
module gsh_checker
  import gsh_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      rstn,
  input wire logic [gsh_pkg::DIO_W-1:0] devDioOe,
  input wire logic [gsh_pkg::CTL_W-1:0] devCtlOe,
  input wire logic [gsh_pkg::DIO_W-1:0] ctlrDioOe,
  input wire logic [gsh_pkg::CTL_W-1:0] ctlrCtlOe,
  input wire logic [gsh_pkg::CTL_W-1:0] ctlLine
);
  wire dav  = ctlLine[CTL_DAV];
  wire nrfd = ctlLine[CTL_NRFD];
  wire ndac = ctlLine[CTL_NDAC];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ==========
  // Wire rules
  // The bounds allow the two-flop line synchronisers plus one state step.
  sequence s_accept;
    ##[1:6] !nrfd ##[1:8] ndac;
  endsequence
  accept_steps_a: assert property ($fell(dav) |-> s_accept)
    else $error("acceptor steps late");
  ctlr_ready_a: assert property ($rose(ctlrCtlOe[CTL_DAV]) |-> nrfd)
    else $error("controller valid before ready");
  dev_ready_a: assert property ($rose(devCtlOe[CTL_DAV]) |-> nrfd)
    else $error("device valid before ready");
  ctlr_hold_a: assert property (ctlrCtlOe[CTL_DAV] |-> $stable(ctlrDioOe))
    else $error("controller data moved");
  dev_hold_a: assert property (devCtlOe[CTL_DAV] |-> $stable(devDioOe))
    else $error("device data moved");
  dav_drop_a: assert property (ndac && !dav |-> ##[1:6] dav)
    else $error("valid held after acceptance");
  ndac_again_a: assert property ($rose(dav) |-> ##[1:6] !ndac)
    else $error("not accepted not reasserted");
  ctlr_release_a: assert property ($fell(ctlrCtlOe[CTL_DAV]) |-> ctlrDioOe == 8'h00)
    else $error("data left on lines");
endmodule // gsh_checker

// ===== sim/tb_gpib_status_and_handshake.sv
// Bench joining the instrument and controller ends over the bus interface.
`timescale 1ns/1ps
module tb_gpib_status_and_handshake;
  import gsh_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, busy = 1'b0, wr = 1'b0, rd = 1'b0, dTx = 1'b0;
  logic [6:0]  ev = 7'h00;
  logic [3:0]  code = 4'h0, addr = 4'h0;
  logic [5:0]  eSet = 6'h00, eClr = 6'h00, ena;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [7:0]  sByte, rxd;
  logic        srq, txDone, rxEnd, rxValid;
  int          n_mismatch = 0, checks = 0, cyc = 0, nRx = 0, nDone = 0;
  // Rows: event line, request class, transfer code, byte without the request bit.
  int          rEv[10] = '{0, 1, 2, 3, 4, 5, 5, 5, 5, 5};
  int          rCls[10] = '{0, 0, 1, 2, 3, 4, 4, 4, 4, 4};
  logic [3:0]  rCode[10] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h3, 4'h4, 4'h5};
  logic [7:0]  rPat[10] = '{8'h02, 8'h02, 8'h22, 8'h21, 8'h50, 8'h90, 8'h92, 8'h93, 8'h94, 8'h95};
  gsh_bus_if link ();
  // A short settle count keeps each byte transfer to a few cycles.
  gsh_instrument #(.SETTLE(2)) gsh_instrument_inst (
    .clk(clk), .rstn(rstn), .bus(link.device), .busy(busy), .evComplete(ev[0]),
    .evEndProgram(ev[1]), .evExecError(ev[2]), .evCommandError(ev[3]),
    .evRequestCommand(ev[4]), .evTransfer(ev[5]), .transferCode(code), .evCheckFail(ev[6]),
    .enableSet(eSet), .enableClear(eClr), .txValid(dTx), .txData(8'hA5), .txEnd(dTx),
    .txDone(txDone), .rxData(rxd), .rxEnd(rxEnd), .rxValid(rxValid), .statusByte(sByte),
    .srqActive(srq), .enables(ena)
  );
  gsh_controller #(.SETTLE(2)) gsh_controller_inst (
    .clk(clk), .rstn(rstn), .bus(link.controller), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata)
  );
  gsh_checker gsh_checker_inst (
    .clk(clk), .rstn(rstn), .devDioOe(link.devDioOe), .devCtlOe(link.devCtlOe),
    .ctlrDioOe(link.ctlrDioOe), .ctlrCtlOe(link.ctlrCtlOe), .ctlLine(link.ctlLine)
  );
  // ==========
  // Clock, timeout and tasks
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    nRx <= nRx + int'(rxValid === 1'b1);
    nDone <= nDone + int'(txDone === 1'b1);
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic close_out();
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk(input logic [7:0] s, input logic q);
    @(negedge clk);
    cmp("status", s, sByte);
    cmp("srq", {7'h00, q}, {7'h00, srq});
    cmp("srq line", {7'h00, ~q}, {7'h00, link.ctlLine[CTL_SRQ]});
    @(posedge clk);
  endtask
  task automatic bw(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic br(input logic [3:0] a, output logic [15:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask
  task automatic wstat(input int b, input logic lvl);
    logic [15:0] v;
    for (int i = 0; i < 100; i++) begin
      br(REG_STAT, v);
      if (v[b] === lvl) break;
    end
  endtask
  task automatic tx(input logic [15:0] d);
    bw(REG_TX, d);
    wstat(1, 1'b0);
  endtask
  // Talk address and poll enable go out under attention, then the controller listens.
  task automatic poll(input logic [7:0] s);
    logic [15:0] v;
    bw(REG_CTRL, 16'h0001);
    tx({9'h000, MSG_TALK, 5'h01});
    tx({9'h000, MSG_SPE});
    bw(REG_CTRL, 16'h0002);
    wstat(2, 1'b1);
    br(REG_RX, v);
    cmp("poll byte", s, v[7:0]);
  endtask
  task automatic pulse(input int i, input logic [3:0] c);
    ev[i] <= 1'b1;
    code <= c;
    @(posedge clk);
    ev[i] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic en(input logic [5:0] s, input logic [5:0] c);
    eSet <= s;
    eClr <= c;
    @(posedge clk);
    eSet <= 6'h00;
    eClr <= 6'h00;
    @(posedge clk);
  endtask
  // ==========
  // Main sequence
  initial begin
    logic [7:0] e;
    logic [15:0] v;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    chk(ST_POWER_ON, 1'b1);
    poll(ST_POWER_ON);
    chk(ST_NORMAL, 1'b0);
    for (int i = 0; i < 10; i++) begin
      e = (rEv[i] == 4) ? rPat[i] : rPat[i] | RQS_MASK;
      pulse(rEv[i], rCode[i]);
      chk(rPat[i], 1'b0);
      en(6'h20 | (6'h01 << rCls[i]), 6'h00);
      cmp("enables", {2'h0, 6'h20 | (6'h01 << rCls[i])}, {2'h0, ena});
      pulse(rEv[i], rCode[i]);
      chk(e, 1'b1);
      poll(e);
      chk(ST_NORMAL, 1'b0);
      en(6'h00, 6'h3F);
    end
    en(6'h1F, 6'h00);
    pulse(2, 4'h0);
    chk(ST_EXEC_ERR, 1'b0);
    pulse(6, 4'h0);
    chk(ST_CHECK_FAIL, 1'b1);
    busy <= 1'b1;
    repeat (2) @(posedge clk);
    chk(ST_CHECK_FAIL | BUSY_MASK, 1'b1);
    poll(ST_CHECK_FAIL | BUSY_MASK);
    chk(BUSY_MASK, 1'b0);
    // The instrument talks one data byte; a poll transfer must not pulse its done flag.
    bw(REG_CTRL, 16'h0001);
    tx(16'h0019);
    dTx <= 1'b1;
    bw(REG_CTRL, 16'h0002);
    while (txDone !== 1'b1) @(negedge clk);
    @(posedge clk);
    dTx <= 1'b0;
    wstat(2, 1'b1);
    br(REG_RX, v);
    cmp("talk byte", 8'hA5, v[7:0]);
    cmp("talk end", 8'h01, {7'h00, v[8]});
    cmp("talk done", 8'h01, nDone[7:0]);
    // The instrument listens to one data byte from the controller.
    bw(REG_CTRL, 16'h0001);
    tx(16'h005F);
    tx(16'h0021);
    bw(REG_CTRL, 16'h0000);
    tx(16'h015A);
    cmp("rx data", 8'h5A, rxd);
    cmp("rx end", 8'h01, {7'h00, rxEnd});
    cmp("rx count", 8'h01, nRx[7:0]);
    rstn <= 1'b0;
    chk(ST_POWER_ON, 1'b1);
    cmp("enables", 8'h00, {2'h0, ena});
    rstn <= 1'b1;
    @(posedge clk);
    chk(ST_POWER_ON | BUSY_MASK, 1'b1);
    close_out();
  end
endmodule // tb_gpib_status_and_handshake
